//--- src/fcd_pkg.sv
package fcd_pkg;

    // Command codes written on the low data byte.
    localparam logic [7:0] FCD_CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] FCD_CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] FCD_CMD_READ_ID      = 8'h90;
    localparam logic [7:0] FCD_CMD_READ_QUERY   = 8'h98;
    localparam logic [7:0] FCD_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] FCD_CMD_WORD_PROG    = 8'h40;
    localparam logic [7:0] FCD_CMD_WORD_PROG_ALT = 8'h10;
    localparam logic [7:0] FCD_CMD_BUF_PROG     = 8'hE8;
    localparam logic [7:0] FCD_CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] FCD_CMD_EFP_SETUP    = 8'h80;
    localparam logic [7:0] FCD_CMD_SUSPEND      = 8'hB0;

    // Status word fields.
    localparam int         FCD_SB_READY     = 7;
    localparam int         FCD_SB_PROG_SUSP = 2;
    localparam logic [7:0] FCD_STATUS_RESET = 8'h80;
    localparam logic [7:0] FCD_ERR_MASK     = 8'h3A;
    localparam logic [7:0] FCD_SEQ_ERR_BITS = 8'h30;

    // Program buffer and bus widths.
    localparam int         FCD_BUF_WORDS = 32;
    localparam int         FCD_BUF_IDX_W = 5;
    localparam int         FCD_ADDR_W    = 23;
    localparam int         FCD_PIN_W     = 4;
    localparam logic [3:0] FCD_PINS_IDLE = 4'hF;

    typedef enum logic [1:0] {
        FCD_MODE_ARRAY,
        FCD_MODE_STATUS,
        FCD_MODE_ID,
        FCD_MODE_QUERY
    } fcd_mode_t;

    typedef enum logic [2:0] {
        FCD_ST_IDLE,
        FCD_ST_PROG_SETUP,
        FCD_ST_PROG_BUSY,
        FCD_ST_BUF_COUNT,
        FCD_ST_BUF_DATA,
        FCD_ST_BUF_CONFIRM,
        FCD_ST_EFP_SETUP,
        FCD_ST_EFP_ACTIVE
    } fcd_state_t;

endpackage

//--- src/fcd_sync.sv
`timescale 1ns/1ns
`default_nettype none

module fcd_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clock,    // System clock.
    input  wire logic             sys_rst,  // Synchronous reset.
    input  wire logic             ce,       // Clock enable.
    input  wire logic [WIDTH-1:0] async_in, // Pin side.
    output logic      [WIDTH-1:0] sync_out  // Clock side.
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // fcd_sync

`default_nettype wire

//--- src/fcd_command_decoder.sv
`timescale 1ns/1ns
`default_nettype none

module fcd_command_decoder
    import fcd_pkg::*;
#(
    parameter int ADDR_W = FCD_ADDR_W
) (
    input  wire logic              clock,             // 20 MHz clock.
    input  wire logic              sys_rst,           // Sync reset, high.
    input  wire logic              ce,                // Clock enable.
    input  wire logic              chip_select_low,   // Pin, active low.
    input  wire logic              write_enable_low,  // Pin, active low.
    input  wire logic              output_enable_low, // Pin, active low.
    input  wire logic              address_valid_low, // Pin, active low.
    input  wire logic [ADDR_W-1:0] addr_pin,          // Address pins.
    input  wire logic [15:0]       data_pin_in,       // Data pins in.
    output logic      [15:0]       data_pin_out,      // Data pins out.
    output logic                   data_pin_oe,       // Data drive enable.
    input  wire logic              burst_read_mode,   // Synchronous reads.
    input  wire logic [15:0]       array_data,        // Array word.
    input  wire logic [15:0]       id_data,           // Identifier word.
    input  wire logic [15:0]       query_data,        // Query word.
    input  wire logic              wsm_busy,          // Machine running.
    input  wire logic              wsm_done,          // Operation ended.
    input  wire logic              wsm_suspended,     // Program suspended.
    input  wire logic [7:0]        wsm_err_set,       // Error set pulses.
    output logic                   prog_start,        // Word program pulse.
    output logic                   buf_load,          // Buffer word pulse.
    output logic                   buf_confirm,       // Buffer start pulse.
    output logic                   efp_start,         // Factory prog pulse.
    output logic                   suspend_req,       // Suspend pulse.
    output logic      [ADDR_W-1:0] op_addr,           // Latched address.
    output logic      [15:0]       op_data,           // Latched data.
    output logic [FCD_BUF_IDX_W-1:0] buf_index,       // Buffer slot.
    output var fcd_mode_t          read_mode,         // Current read mode.
    output logic      [7:0]        status_word        // Status snapshot.
);

    function automatic logic [15:0] read_word(
        input fcd_mode_t   mode,
        input logic [15:0] arr,
        input logic [15:0] ident,
        input logic [15:0] query,
        input logic [7:0]  stat
    );
        logic [15:0] w;
        w = arr;
        unique case (mode)
            FCD_MODE_ARRAY:  w = arr;
            FCD_MODE_STATUS: w = {8'h00, stat};
            FCD_MODE_ID:     w = ident;
            FCD_MODE_QUERY:  w = {8'h00, query[7:0]};
        endcase
        return w;
    endfunction

    function automatic logic busy_allowed(input logic [7:0] code);
        return (code == FCD_CMD_READ_STATUS) || (code == FCD_CMD_SUSPEND);
    endfunction

    logic [FCD_PIN_W-1:0] pins_s;
    logic [ADDR_W-1:0]    addr_s;
    logic [15:0]          data_s;

    fcd_sync #(.WIDTH(FCD_PIN_W), .RST_VAL(FCD_PINS_IDLE)) u_pin_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .async_in ({address_valid_low, output_enable_low,
                    write_enable_low, chip_select_low}),
        .sync_out (pins_s)
    );

    fcd_sync #(.WIDTH(ADDR_W + 16), .RST_VAL('0)) u_bus_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .async_in ({addr_pin, data_pin_in}),
        .sync_out ({addr_s, data_s})
    );

    logic cs_s, we_s, oe_s, adv_s;
    assign {adv_s, oe_s, we_s, cs_s} = pins_s;

    fcd_state_t             state_q, state_d;
    fcd_mode_t              mode_q, mode_d;
    logic [FCD_PIN_W-1:0]   pins_prev_q;
    logic [7:0]             err_q, err_d, snap_q, snap_d;
    logic [15:0]            dout_q, dout_d;
    logic                   doe_q, doe_d;
    logic                   prog_q, prog_d, load_q, load_d;
    logic                   conf_q, conf_d, efp_q, efp_d, susp_q, susp_d;
    logic [ADDR_W-1:0]      addr_q, addr_d;
    logic [15:0]            opd_q, opd_d;
    logic [FCD_BUF_IDX_W-1:0] cnt_q, cnt_d, idx_q, idx_d, slot_q, slot_d;
    logic                   clr_err, seq_err, cmd_wr, refresh;
    logic [7:0]             cmd, live_status;

    // A write is taken when the synced write enable rises while selected.
    assign cmd_wr = we_s && !pins_prev_q[1] && !cs_s;
    assign cmd    = data_s[7:0];

    assign refresh = (!cs_s && pins_prev_q[0]) ||
                     (burst_read_mode ? (!adv_s && pins_prev_q[3])
                                      : (!oe_s && pins_prev_q[2]));

    always_comb begin
        live_status = err_q;
        live_status[FCD_SB_READY]     = !wsm_busy || wsm_suspended;
        live_status[FCD_SB_PROG_SUSP] = wsm_suspended;
    end

    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        clr_err = 1'b0;
        seq_err = 1'b0;
        prog_d  = 1'b0;
        load_d  = 1'b0;
        conf_d  = 1'b0;
        efp_d   = 1'b0;
        susp_d  = 1'b0;
        addr_d  = addr_q;
        opd_d   = opd_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        slot_d  = slot_q;
        if (cmd_wr) begin
            unique case (state_q)
                FCD_ST_IDLE: begin
                    case (cmd)
                        FCD_CMD_READ_ARRAY:   mode_d = FCD_MODE_ARRAY;
                        FCD_CMD_READ_STATUS:  mode_d = FCD_MODE_STATUS;
                        FCD_CMD_READ_ID:      mode_d = FCD_MODE_ID;
                        FCD_CMD_READ_QUERY:   mode_d = FCD_MODE_QUERY;
                        FCD_CMD_CLEAR_STATUS: clr_err = 1'b1;
                        FCD_CMD_WORD_PROG, FCD_CMD_WORD_PROG_ALT: begin
                            state_d = FCD_ST_PROG_SETUP;
                            mode_d  = FCD_MODE_STATUS;
                        end
                        FCD_CMD_BUF_PROG: begin
                            state_d = FCD_ST_BUF_COUNT;
                            mode_d  = FCD_MODE_STATUS;
                        end
                        FCD_CMD_EFP_SETUP: begin
                            state_d = FCD_ST_EFP_SETUP;
                            mode_d  = FCD_MODE_STATUS;
                        end
                        default: ;
                    endcase
                end
                FCD_ST_PROG_SETUP: begin
                    prog_d  = 1'b1;
                    addr_d  = addr_s;
                    opd_d   = data_s;
                    state_d = FCD_ST_PROG_BUSY;
                end
                FCD_ST_PROG_BUSY: begin
                    if (busy_allowed(cmd)) begin
                        if (cmd == FCD_CMD_SUSPEND) begin
                            susp_d = 1'b1;
                        end else begin
                            mode_d = FCD_MODE_STATUS;
                        end
                    end
                end
                FCD_ST_BUF_COUNT: begin
                    // Counts beyond the buffer are clamped to its last slot.
                    cnt_d   = (data_s[15:FCD_BUF_IDX_W] != '0) ?
                              FCD_BUF_IDX_W'(FCD_BUF_WORDS - 1) :
                              data_s[FCD_BUF_IDX_W-1:0];
                    idx_d   = '0;
                    addr_d  = addr_s;
                    state_d = FCD_ST_BUF_DATA;
                end
                FCD_ST_BUF_DATA: begin
                    load_d = 1'b1;
                    addr_d = addr_s;
                    opd_d  = data_s;
                    slot_d = idx_q;
                    idx_d  = FCD_BUF_IDX_W'(idx_q + 1'b1);
                    if (idx_q == cnt_q) begin
                        state_d = FCD_ST_BUF_CONFIRM;
                    end
                end
                FCD_ST_BUF_CONFIRM: begin
                    if (cmd == FCD_CMD_CONFIRM) begin
                        conf_d  = 1'b1;
                        state_d = FCD_ST_PROG_BUSY;
                    end else begin
                        seq_err = 1'b1;
                        state_d = FCD_ST_IDLE;
                    end
                end
                FCD_ST_EFP_SETUP: begin
                    if (cmd == FCD_CMD_CONFIRM) begin
                        efp_d   = 1'b1;
                        addr_d  = addr_s;
                        opd_d   = data_s;
                        state_d = FCD_ST_EFP_ACTIVE;
                    end
                end
                FCD_ST_EFP_ACTIVE: ;
            endcase
        end
        if (wsm_done && (state_q == FCD_ST_PROG_BUSY ||
                         state_q == FCD_ST_EFP_ACTIVE)) begin
            state_d = FCD_ST_IDLE;
        end
    end

    always_comb begin
        // A set arriving with a clear wins.
        err_d = (err_q & ~(clr_err ? FCD_ERR_MASK : 8'h00))
              | (wsm_err_set & FCD_ERR_MASK)
              | (seq_err ? FCD_SEQ_ERR_BITS : 8'h00);
        snap_d = refresh ? live_status : snap_q;
        dout_d = read_word(mode_q, array_data, id_data, query_data, snap_q);
        doe_d  = !cs_s && !oe_s && we_s;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q     <= FCD_ST_IDLE;
            mode_q      <= FCD_MODE_ARRAY;
            err_q       <= 8'h00;
            snap_q      <= FCD_STATUS_RESET;
            pins_prev_q <= FCD_PINS_IDLE;
            dout_q      <= 16'h0000;
            doe_q       <= 1'b0;
            prog_q      <= 1'b0;
            load_q      <= 1'b0;
            conf_q      <= 1'b0;
            efp_q       <= 1'b0;
            susp_q      <= 1'b0;
            addr_q      <= '0;
            opd_q       <= 16'h0000;
            cnt_q       <= '0;
            idx_q       <= '0;
            slot_q      <= '0;
        end else if (ce) begin
            state_q     <= state_d;
            mode_q      <= mode_d;
            err_q       <= err_d;
            snap_q      <= snap_d;
            pins_prev_q <= pins_s;
            dout_q      <= dout_d;
            doe_q       <= doe_d;
            prog_q      <= prog_d;
            load_q      <= load_d;
            conf_q      <= conf_d;
            efp_q       <= efp_d;
            susp_q      <= susp_d;
            addr_q      <= addr_d;
            opd_q       <= opd_d;
            cnt_q       <= cnt_d;
            idx_q       <= idx_d;
            slot_q      <= slot_d;
        end
    end

    assign data_pin_out = dout_q;
    assign data_pin_oe  = doe_q;
    assign prog_start   = prog_q;
    assign buf_load     = load_q;
    assign buf_confirm  = conf_q;
    assign efp_start    = efp_q;
    assign suspend_req  = susp_q;
    assign op_addr      = addr_q;
    assign op_data      = opd_q;
    assign buf_index    = slot_q;
    assign read_mode    = mode_q;
    assign status_word  = snap_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence idle_cmd(logic [7:0] code);
        ce && cmd_wr && state_q == FCD_ST_IDLE && cmd == code;
    endsequence
    sequence taken_in(fcd_state_t st);
        ce && cmd_wr && state_q == st && !wsm_done;
    endsequence
    read_array_a: assert property (idle_cmd(FCD_CMD_READ_ARRAY)
        |=> mode_q == FCD_MODE_ARRAY) else $error("FF not array");
    read_status_a: assert property (idle_cmd(FCD_CMD_READ_STATUS)
        |=> mode_q == FCD_MODE_STATUS) else $error("70 not status");
    auto_status_a: assert property (idle_cmd(FCD_CMD_WORD_PROG)
        |=> mode_q == FCD_MODE_STATUS) else $error("no auto status");
    id_mode_a: assert property (idle_cmd(FCD_CMD_READ_ID)
        |=> mode_q == FCD_MODE_ID) else $error("90 not id");
    query_byte_a: assert property (ce && mode_q == FCD_MODE_QUERY
        |=> dout_q[15:8] == 8'h00) else $error("query high byte");
    err_clear_a: assert property ((($past(err_q) & ~err_q) != 8'h00)
        |-> $past(clr_err && ce)) else $error("error bit lost");
    word_prog_a: assert property (taken_in(FCD_ST_PROG_SETUP)
        |=> prog_q && addr_q == $past(addr_s) && opd_q == $past(data_s))
        else $error("no start");
    busy_gate_a: assert property (taken_in(FCD_ST_PROG_BUSY)
        && !busy_allowed(cmd) |=> $stable(mode_q) && !susp_q && !prog_q)
        else $error("busy took command");
    snap_hold_a: assert property (snap_q != $past(snap_q)
        |-> $past(refresh && ce)) else $error("status moved");
    buf_count_a: assert property (load_q |-> slot_q <= $past(cnt_q))
        else $error("buffer overrun");
    buf_conf_a: assert property (conf_q
        |-> $past(state_q) == FCD_ST_BUF_CONFIRM) else $error("bad conf");
    efp_ignore_a: assert property (taken_in(FCD_ST_EFP_SETUP)
        && cmd != FCD_CMD_CONFIRM |=> state_q == FCD_ST_EFP_SETUP
        && $stable(mode_q)) else $error("efp took command");
    efp_start_a: assert property (efp_q
        |-> $past(state_q) == FCD_ST_EFP_SETUP) else $error("stray efp");
    reset_state_a: assert property ($past(sys_rst) |-> mode_q ==
        FCD_MODE_ARRAY && snap_q == FCD_STATUS_RESET && err_q == 8'h00)
        else $error("bad reset state");
    suspend_a: assert property (taken_in(FCD_ST_PROG_BUSY)
        && cmd == FCD_CMD_SUSPEND |=> susp_q) else $error("no suspend");

endmodule // fcd_command_decoder

`default_nettype wire

//--- tb/fcd_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module fcd_host_model
    import fcd_pkg::*;
(
    input  wire logic                  clock,             // Clock.
    output logic                       chip_select_low,   // Select.
    output logic                       write_enable_low,  // Write.
    output logic                       output_enable_low, // Read.
    output logic                       address_valid_low, // Valid.
    output logic      [FCD_ADDR_W-1:0] addr_pin,          // Address.
    output logic      [15:0]           data_pin_in,       // Data out.
    input  wire logic [15:0]           data_pin_out,      // Data in.
    input  wire logic                  data_pin_oe        // Driven.
);
    initial begin
        chip_select_low = 1'b1;
        write_enable_low = 1'b1;
        output_enable_low = 1'b1;
        address_valid_low = 1'b1;
        addr_pin = '0;
        data_pin_in = 16'h0000;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask

    // Strobe low and high long enough to pass the pin synchronisers.
    task automatic write_word(input logic [FCD_ADDR_W-1:0] a,
                              input logic [15:0] d);
        chip_select_low = 1'b0;
        write_enable_low = 1'b0;
        addr_pin = a;
        data_pin_in = d;
        step(3);
        write_enable_low = 1'b1;
        step(4);
        chip_select_low = 1'b1;
        addr_pin = ~a;
        data_pin_in = ~d;
        step(2);
    endtask

    // Every read drops select and enable afresh.
    task automatic read_word(output logic [15:0] d, output logic oe);
        chip_select_low = 1'b0;
        output_enable_low = 1'b0;
        address_valid_low = 1'b0;
        step(6);
        d = data_pin_out;
        oe = data_pin_oe;
        chip_select_low = 1'b1;
        output_enable_low = 1'b1;
        address_valid_low = 1'b1;
        step(3);
    endtask

    // Select alone, so that it can stay low across several strobes.
    task automatic select(input logic level);
        chip_select_low = level;
        step(3);
    endtask

    // One enable or valid strobe while select stays where it is.
    task automatic strobe(input logic by_valid);
        if (by_valid) address_valid_low = 1'b0;
        else output_enable_low = 1'b0;
        step(3);
        output_enable_low = 1'b1;
        address_valid_low = 1'b1;
        step(3);
    endtask
endmodule // fcd_host_model

`default_nettype wire

//--- tb/fcd_command_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none

`define CHECK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end

module fcd_command_decoder_test import fcd_pkg::*;;
    typedef struct {
        logic [7:0]  cmd;
        fcd_mode_t   mode;
        logic [15:0] word;
    } fcd_row_t;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    wire  cs_n, we_n, oe_n, adv_n;
    wire  [FCD_ADDR_W-1:0] addr;
    wire  [15:0] din;
    logic [15:0] data_pin_out, rd;
    logic data_pin_oe, rd_oe;
    logic wsm_busy = 1'b0, wsm_done = 1'b0, wsm_suspended = 1'b0;
    logic [7:0] wsm_err_set = 8'h00;
    logic ce = 1'b1, burst = 1'b0;
    logic [15:0] arr_w = 16'hA5C3, id_w = 16'h1234, qry_w = 16'h5A7E;
    logic prog_start, buf_load, buf_confirm, efp_start, suspend_req;
    logic [FCD_ADDR_W-1:0] op_addr, last_addr;
    logic [15:0] op_data, last_data;
    logic [FCD_BUF_IDX_W-1:0] buf_index, last_idx;
    fcd_mode_t read_mode, m0;
    logic [7:0] status_word;
    logic [7:0] setup [2] = '{FCD_CMD_WORD_PROG, FCD_CMD_WORD_PROG_ALT};
    int bad_count = 0, checked = 0;
    int n_prog = 0, n_load = 0, n_conf = 0, n_efp = 0, n_susp = 0, p0;
    fcd_row_t rows [5] = '{
        '{FCD_CMD_READ_STATUS, FCD_MODE_STATUS, 16'h0080},
        '{FCD_CMD_READ_ID,     FCD_MODE_ID,     16'h1234},
        '{FCD_CMD_READ_QUERY,  FCD_MODE_QUERY,  16'h007E},
        '{8'h33,               FCD_MODE_QUERY,  16'h007E},
        '{FCD_CMD_READ_ARRAY,  FCD_MODE_ARRAY,  16'hA5C3}};

    always #25 clock = ~clock;

    fcd_host_model i_fcd_host_model (.clock(clock),
        .chip_select_low(cs_n), .write_enable_low(we_n),
        .output_enable_low(oe_n), .address_valid_low(adv_n),
        .addr_pin(addr), .data_pin_in(din),
        .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));

    fcd_command_decoder #(.ADDR_W(FCD_ADDR_W)) i_fcd_command_decoder (
        .clock(clock), .sys_rst(sys_rst), .ce(ce),
        .chip_select_low(cs_n), .write_enable_low(we_n),
        .output_enable_low(oe_n), .address_valid_low(adv_n),
        .addr_pin(addr), .data_pin_in(din), .data_pin_out(data_pin_out),
        .data_pin_oe(data_pin_oe), .burst_read_mode(burst),
        .array_data(arr_w), .id_data(id_w), .query_data(qry_w),
        .wsm_busy(wsm_busy), .wsm_done(wsm_done),
        .wsm_suspended(wsm_suspended), .wsm_err_set(wsm_err_set),
        .prog_start(prog_start), .buf_load(buf_load),
        .buf_confirm(buf_confirm), .efp_start(efp_start),
        .suspend_req(suspend_req), .op_addr(op_addr), .op_data(op_data),
        .buf_index(buf_index), .read_mode(read_mode),
        .status_word(status_word));

    always @(posedge clock) begin
        if (prog_start === 1'b1) begin
            n_prog++;
            last_addr = op_addr;
            last_data = op_data;
        end
        if (buf_load === 1'b1) begin
            n_load++;
            last_idx = buf_index;
        end
        if (buf_confirm === 1'b1) n_conf++;
        if (efp_start === 1'b1) n_efp++;
        if (suspend_req === 1'b1) n_susp++;
    end

    task automatic wr(input logic [7:0] c);
        i_fcd_host_model.write_word(23'h000000, {8'h00, c});
    endtask

    task automatic rd_word();
        i_fcd_host_model.read_word(rd, rd_oe);
    endtask

    task automatic finish_wsm();
        wsm_busy = 1'b0;
        wsm_done = 1'b1;
        i_fcd_host_model.step(1);
        wsm_done = 1'b0;
        i_fcd_host_model.step(1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clock);
        #5;
        sys_rst = 1'b0;
        `CHECK("reset mode", FCD_MODE_ARRAY, read_mode)
        `CHECK("reset status", FCD_STATUS_RESET, status_word)
        rd_word();
        `CHECK("reset read", 16'hA5C3, rd)
        `CHECK("read drive", 1'b1, rd_oe)
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].cmd);
            `CHECK("mode", rows[i].mode, read_mode)
            rd_word();
            `CHECK("read word", rows[i].word, rd)
        end
        $display("test table done");
        foreach (setup[i]) begin
            p0 = n_prog;
            wr(setup[i]);
            `CHECK("setup mode", FCD_MODE_STATUS, read_mode)
            i_fcd_host_model.write_word(FCD_ADDR_W'(23'h012340 + i),
                                        16'(16'hBEE0 + i));
            `CHECK("prog count", p0 + 1, n_prog)
            `CHECK("prog addr", 23'h012340 + i, last_addr)
            `CHECK("prog data", 16'hBEE0 + i, last_data)
            wsm_busy = 1'b1;
            p0 = n_susp;
            wr(FCD_CMD_READ_ID);
            `CHECK("busy ignore", FCD_MODE_STATUS, read_mode)
            rd_word();
            `CHECK("busy status", 16'h0000, rd)
            wr(FCD_CMD_SUSPEND);
            `CHECK("suspend", p0 + 1, n_susp)
            wsm_suspended = 1'b1;
            rd_word();
            `CHECK("susp status", 16'h0084, rd)
            wsm_suspended = 1'b0;
            finish_wsm();
            `CHECK("after prog", FCD_MODE_STATUS, read_mode)
            wr(FCD_CMD_READ_ARRAY);
            `CHECK("array again", FCD_MODE_ARRAY, read_mode)
        end
        $display("test program done");
        wsm_err_set = 8'hFF;
        i_fcd_host_model.step(1);
        wsm_err_set = 8'h00;
        i_fcd_host_model.step(2);
        `CHECK("no refresh", 8'h80, status_word)
        wr(FCD_CMD_READ_STATUS);
        rd_word();
        `CHECK("errors", {8'h00, 8'h80 | FCD_ERR_MASK}, rd)
        wr(FCD_CMD_READ_ARRAY);
        wr(FCD_CMD_READ_STATUS);
        rd_word();
        `CHECK("errors kept", 16'h00BA, rd)
        wr(FCD_CMD_CLEAR_STATUS);
        rd_word();
        `CHECK("cleared", 16'h0080, rd)
        $display("test status done");
        p0 = n_load;
        wr(FCD_CMD_BUF_PROG);
        i_fcd_host_model.write_word(23'h000100, 16'h001F);
        for (int k = 0; k < 32; k++) begin
            i_fcd_host_model.write_word(FCD_ADDR_W'(23'h000100 + k),
                                        16'(16'hC000 + k));
        end
        `CHECK("loads", p0 + 32, n_load)
        `CHECK("last slot", 5'h1F, last_idx)
        p0 = n_conf;
        wr(FCD_CMD_CONFIRM);
        `CHECK("confirm", p0 + 1, n_conf)
        finish_wsm();
        wr(FCD_CMD_BUF_PROG);
        i_fcd_host_model.write_word(23'h000100, 16'h0000);
        i_fcd_host_model.write_word(23'h000100, 16'h1111);
        wr(FCD_CMD_READ_ARRAY);
        `CHECK("no confirm", p0 + 1, n_conf)
        rd_word();
        `CHECK("seq error", 16'h00B0, rd)
        wr(FCD_CMD_CLEAR_STATUS);
        $display("test buffer done");
        p0 = n_efp;
        wr(FCD_CMD_CONFIRM);
        `CHECK("idle confirm", p0, n_efp)
        wr(FCD_CMD_EFP_SETUP);
        m0 = read_mode;
        wr(FCD_CMD_READ_ID);
        `CHECK("efp ignore", m0, read_mode)
        i_fcd_host_model.write_word(23'h000777, {8'h00, FCD_CMD_CONFIRM});
        `CHECK("efp start", p0 + 1, n_efp)
        `CHECK("efp addr", 23'h000777, op_addr)
        `CHECK("efp data", {8'h00, FCD_CMD_CONFIRM}, op_data)
        finish_wsm();
        $display("test factory done");
        ce = 1'b0;
        wr(FCD_CMD_READ_ARRAY);
        ce = 1'b1;
        i_fcd_host_model.step(2);
        `CHECK("frozen mode", FCD_MODE_STATUS, read_mode)
        $display("test enable done");
        burst = 1'b1;
        i_fcd_host_model.select(1'b0);
        wsm_err_set = 8'h02;
        i_fcd_host_model.step(1);
        wsm_err_set = 8'h00;
        i_fcd_host_model.strobe(1'b0);
        `CHECK("oe in burst", 8'h80, status_word)
        i_fcd_host_model.strobe(1'b1);
        `CHECK("adv in burst", 8'h82, status_word)
        burst = 1'b0;
        wsm_err_set = 8'h08;
        i_fcd_host_model.step(1);
        wsm_err_set = 8'h00;
        i_fcd_host_model.strobe(1'b1);
        `CHECK("adv in async", 8'h82, status_word)
        i_fcd_host_model.strobe(1'b0);
        `CHECK("oe in async", 8'h8A, status_word)
        i_fcd_host_model.select(1'b1);
        $display("test refresh done");
        sys_rst = 1'b1;
        i_fcd_host_model.step(2);
        sys_rst = 1'b0;
        `CHECK("rerun mode", FCD_MODE_ARRAY, read_mode)
        `CHECK("rerun status", FCD_STATUS_RESET, status_word)
        `CHECK("rerun drive", 1'b0, data_pin_oe)
        wr(FCD_CMD_READ_STATUS);
        rd_word();
        `CHECK("rerun errors", 16'h0080, rd)
        $display("test rerun done");
        complete_run();
    end
endmodule // fcd_command_decoder_test

`default_nettype wire
